// ==== logic/itc_channel.sv ====
`timescale 1ns/1ns
// Functional notes
// [R1] Event mode: control word drives output low.
// [R2] Event mode: gate high counts, low holds.
// [R3] Event mode: count loads undecremented, N+1 clocks.
// [R4] Event mode: first byte suspends, output drops.
// [R5] Event mode: load ignores gate; N after gate.
// [R6] One-shot: high, trigger loads, low N clocks.
// [R7] One-shot: gate rise retriggers from holding value.
// [R8] One-shot: new count waits for next trigger.
// [R9] Rate: low one clock at one, reload.
// [R10] Rate: gate low inhibits, forces output high.
// [R11] Rate: load next edge, low after N.
// [R12] Rate: new count at cycle end or trigger.
// [R13] Processor never writes count one in rate.
// [R14] Zero count means 10000H clocks everywhere; in decimal the code wraps zero to 9999, 10000 clocks.
// [R15] Square: high first half, low rest.
// [R16] Square: gate low inhibits, forces high.
// [R17] Square: new count at half-cycle end.
// [R18] Square even: step two, toggle at two.
// [R19] Square odd: load N-1, toggle 0/2.
// [R20] Square odd: high (N+1)/2, low (N-1)/2.
// [R21] Mode field selects the waveform mode.
// [R22] Access field sets count byte format.
// [R23] Control bit selects binary or decimal.
// [R24] Count only on count-clock falling edges.
module itc_channel (
  input  wire logic        clk,         // System clock, 50 MHz.
  input  wire logic        rstn,        // Asynchronous reset, active low.
  input  wire logic        ctlWrite,    // Control word write pulse.
  input  wire logic        countWrite,  // Count byte write pulse.
  input  wire logic [7:0]  busData,     // Written byte.
  input  wire logic        countClk,    // Channel count clock.
  input  wire logic        gate,        // Channel gate.
  output logic             chanOut,     // Channel output, registered.
  output logic      [15:0] countValue   // Counting element, registered.
);

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  itc_pkg::itc_ctrl_type  ctrlReg;
  itc_pkg::itc_ctrl_type  ctlIn;
  itc_pkg::itc_phase_type phaseReg;
  itc_pkg::itc_phase_type phaseNext;
  logic [15:0] ceReg;
  logic [15:0] ceNext;
  logic        outReg;
  logic        outNext;
  logic        oddReg;
  logic        oddNext;
  logic        clkPrevReg;
  logic        gatePrevReg;
  logic        trigReg;
  logic [15:0] holdValue;
  logic        countDone;
  logic        firstByte;
  logic [15:0] dec1;
  logic [15:0] dec2;

  // Decrement by one, in binary or in four decimal digits.
  function automatic logic [15:0] decCount(input logic [15:0] v, input logic bcd);
    logic [15:0] r;
    logic        borrow;
    r = v;
    borrow = 1'b1;
    if (!bcd) begin
      r = v - itc_pkg::CNT_ONE;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (borrow) begin
          if (v[4*i +: 4] == 4'h0) begin
            r[4*i +: 4] = 4'h9;
          end else begin
            r[4*i +: 4] = v[4*i +: 4] - 4'h1;
            borrow = 1'b0;
          end
        end
      end
    end
    return r;
  endfunction

  // --------------------------------------------------------------------------
  // Decoding
  // --------------------------------------------------------------------------
  // A latch command leaves the mode untouched; a zero count wraps to the top.
  assign ctlIn      = busData;
  wire ctrlAccept   = ctlWrite && ctlIn.access != itc_pkg::ACC_LATCH;  // [R22]
  wire clkFall      = clkPrevReg && !countClk;                          // [R24]
  wire gateRise     = gate && !gatePrevReg;
  wire isEvent      = ctrlReg.mode == itc_pkg::MODE_EVENT;              // [R21]
  wire isShot       = ctrlReg.mode == itc_pkg::MODE_SHOT;               // [R21]
  wire isRate       = ctrlReg.mode[1:0] == itc_pkg::RATE_LOW2;          // [R21]
  wire isSquare     = ctrlReg.mode[1:0] == itc_pkg::SQUARE_LOW2;        // [R21]
  wire [15:0] sqLoad = {holdValue[15:1], 1'b0};                        // [R19]
  wire sqEnd        = (oddReg && outReg) ? ceReg == itc_pkg::CNT_ZERO :
                                           ceReg == itc_pkg::CNT_TWO;   // [R18] [R19]
  assign dec1 = decCount(ceReg, ctrlReg.bcd);                           // [R23] [R14]
  assign dec2 = decCount(dec1, ctrlReg.bcd);

  // --------------------------------------------------------------------------
  // Count holding register
  // --------------------------------------------------------------------------
  itc_count_hold holdUnit (
    .clk       (clk),
    .rstn      (rstn),
    .ctlWrite  (ctrlAccept),
    .access    (ctrlReg.access),
    .byteWrite (countWrite),
    .byteData  (busData),
    .holdValue (holdValue),
    .countDone (countDone),
    .firstByte (firstByte)
  );

  // --------------------------------------------------------------------------
  // Next state of the counting element and the output
  // --------------------------------------------------------------------------
  // Writes win over a count edge in the same cycle; gate-low forcing is last.
  always_comb begin
    phaseNext = phaseReg;
    ceNext    = ceReg;
    outNext   = outReg;
    oddNext   = oddReg;
    if (ctrlAccept) begin
      phaseNext = itc_pkg::PH_IDLE;
      ceNext    = itc_pkg::CNT_ZERO;
      outNext   = ctlIn.mode != itc_pkg::MODE_EVENT;                    // [R1] [R6] [R9] [R15]
    end else if (isEvent && firstByte) begin
      phaseNext = itc_pkg::PH_IDLE;                                     // [R4]
      outNext   = 1'b0;                                                 // [R4]
    end else if (countDone) begin
      if (isEvent) begin
        phaseNext = itc_pkg::PH_LOAD;                                   // [R3] [R5]
        outNext   = 1'b0;                                               // [R1]
      end else if (phaseReg == itc_pkg::PH_IDLE) begin
        phaseNext = isShot ? itc_pkg::PH_ARMED : itc_pkg::PH_LOAD;      // [R8] [R11]
      end
    end else if (clkFall) begin
      unique case (phaseReg)
        itc_pkg::PH_IDLE: begin
        end
        itc_pkg::PH_LOAD: begin
          ceNext    = isSquare ? sqLoad : holdValue;                    // [R3] [R11] [R19]
          oddNext   = holdValue[0];
          phaseNext = itc_pkg::PH_RUN;
        end
        itc_pkg::PH_ARMED: begin
          if (isShot && trigReg) begin
            ceNext    = holdValue;                                      // [R6]
            outNext   = 1'b0;                                           // [R6]
            phaseNext = itc_pkg::PH_RUN;
          end
        end
        itc_pkg::PH_RUN: begin
          if (isEvent && gate) begin
            ceNext = dec1;                                              // [R2]
            if (ceReg == itc_pkg::CNT_ONE) begin
              outNext = 1'b1;                                           // [R1]
            end
          end else if (isShot && trigReg) begin
            ceNext = holdValue;                                         // [R7] [R8]
            outNext = 1'b0;
          end else if (isShot) begin
            ceNext = dec1;
            if (ceReg == itc_pkg::CNT_ONE) begin
              outNext   = 1'b1;                                         // [R6]
              phaseNext = itc_pkg::PH_ARMED;
            end
          end else if (isRate && trigReg) begin
            ceNext  = holdValue;                                        // [R10] [R12]
            outNext = 1'b1;
          end else if (isRate && gate) begin
            if (ceReg == itc_pkg::CNT_TWO) begin
              ceNext  = dec1;
              outNext = 1'b0;                                           // [R9]
            end else if (ceReg == itc_pkg::CNT_ONE) begin
              ceNext  = holdValue;                                      // [R9] [R12]
              outNext = 1'b1;
            end else begin
              ceNext = dec1;
            end
          end else if (isSquare && trigReg) begin
            ceNext  = sqLoad;                                           // [R16] [R17]
            oddNext = holdValue[0];
            outNext = 1'b1;
          end else if (isSquare && gate) begin
            if (sqEnd) begin
              ceNext  = sqLoad;                                         // [R17] [R18]
              oddNext = holdValue[0];
              outNext = !outReg;                                        // [R15] [R20]
            end else begin
              ceNext = dec2;                                            // [R18] [R19]
            end
          end
        end
      endcase
    end
    if (!ctrlAccept && (isRate || isSquare) && !gate) begin
      outNext = 1'b1;                                                   // [R10] [R16]
    end
  end

  // --------------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------------
  // Control word store.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctrlReg <= itc_pkg::CTRL_RESET;
    end else if (ctrlAccept) begin
      ctrlReg <= ctlIn;                                                 // [R21] [R22] [R23]
    end
  end

  // Edge history and the trigger latch; a new rise wins over the clear.
  // Gate history resets high, so a gate held high through reset is no trigger.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      clkPrevReg  <= 1'b0;
      gatePrevReg <= 1'b1;
      trigReg     <= 1'b0;
    end else begin
      clkPrevReg  <= countClk;
      gatePrevReg <= gate;
      trigReg     <= gateRise || (trigReg && !clkFall);                 // [R7]
    end
  end

  // Counting element, phase and output.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      phaseReg <= itc_pkg::PH_IDLE;
      ceReg    <= itc_pkg::CNT_ZERO;
      outReg   <= 1'b0;
      oddReg   <= 1'b0;
    end else begin
      phaseReg <= phaseNext;
      ceReg    <= ceNext;
      outReg   <= outNext;
      oddReg   <= oddNext;
    end
  end

  assign chanOut    = outReg;
  assign countValue = ceReg;

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  event_ctl_low_a : assert property (@(posedge clk) disable iff (!rstn) // [R1]
    ctrlAccept && ctlIn.mode == itc_pkg::MODE_EVENT |=> !chanOut)
    else $error("Event mode control word did not drop the output.");

  event_gate_hold_a : assert property (@(posedge clk) disable iff (!rstn) // [R2]
    isEvent && phaseReg == itc_pkg::PH_RUN && clkFall && !gate && !ctrlAccept
    && !countDone && !firstByte |=> $stable(countValue) && $stable(chanOut))
    else $error("Event mode counted or moved the output with gate low.");

  event_load_a : assert property (@(posedge clk) disable iff (!rstn) // [R3]
    isEvent && phaseReg == itc_pkg::PH_LOAD && clkFall && !ctrlAccept && !countDone
    && !firstByte |=> countValue == $past(holdValue) && !chanOut)
    else $error("Event mode load was decremented or raised the output.");

  first_byte_a : assert property (@(posedge clk) disable iff (!rstn) // [R4]
    isEvent && firstByte && !ctrlAccept |=> !chanOut ##1 (phaseReg != itc_pkg::PH_RUN))
    else $error("First count byte did not suspend the event counter.");

  shot_ctl_high_a : assert property (@(posedge clk) disable iff (!rstn) // [R6]
    ctrlAccept && ctlIn.mode == itc_pkg::MODE_SHOT |=> chanOut)
    else $error("One-shot control word did not raise the output.");

  rate_pulse_a : assert property (@(posedge clk) disable iff (!rstn) // [R9]
    isRate && phaseReg == itc_pkg::PH_RUN && clkFall && gate && !trigReg
    && countValue == itc_pkg::CNT_TWO && !ctrlAccept && !countDone
    |=> !chanOut && countValue == itc_pkg::CNT_ONE)
    else $error("Rate generator missed its low pulse at count one.");

  gate_force_a : assert property (@(posedge clk) disable iff (!rstn) // [R10]
    (isRate || isSquare) && !gate && !ctrlAccept |=> chanOut)
    else $error("Gate low did not force the output high.");

  square_toggle_a : assert property (@(posedge clk) disable iff (!rstn) // [R18]
    isSquare && phaseReg == itc_pkg::PH_RUN && clkFall && gate && !trigReg && sqEnd
    && !ctrlAccept && !countDone |=> chanOut != $past(chanOut))
    else $error("Square wave did not toggle at the end of a half cycle.");

  bcd_digits_a : assert property (@(posedge clk) disable iff (!rstn) // [R23]
    ctrlReg.bcd && $changed(countValue) && phaseReg == itc_pkg::PH_RUN && isEvent
    && $past(phaseReg) == itc_pkg::PH_RUN
    && $past(countValue[3:0]) == 4'h0 && !$past(countDone) |-> countValue[3:0] == 4'h9)
    else $error("Decimal count did not borrow from the next digit.");

  shot_count_wait_a : assert property (@(posedge clk) disable iff (!rstn) // [R8]
    isShot && phaseReg == itc_pkg::PH_RUN && countDone && !ctrlAccept
    |=> $stable(countValue) && $stable(chanOut))
    else $error("One-shot pulse changed when a new count was written.");

  square_load_a : assert property (@(posedge clk) disable iff (!rstn) // [R19]
    isSquare && phaseReg == itc_pkg::PH_LOAD && clkFall && !ctrlAccept && !countDone
    |=> !countValue[0] && countValue[15:1] == $past(holdValue[15:1]) && chanOut)
    else $error("Square wave load did not drop bit zero of the count.");

  fall_only_a : assert property (@(posedge clk) disable iff (!rstn) // [R24]
    !clkFall && !ctrlAccept |=> $stable(countValue))
    else $error("Counting element moved without a count-clock fall.");

endmodule // itc_channel

// ==== logic/itc_count_hold.sv ====
`timescale 1ns/1ns
// ----------------------------------------------------------------------------
// Count holding register: gathers count bytes in the programmed format.
// ----------------------------------------------------------------------------
module itc_count_hold (
  input  wire logic        clk,         // System clock.
  input  wire logic        rstn,        // Asynchronous reset, active low.
  input  wire logic        ctlWrite,    // Control word write pulse.
  input  wire logic [1:0]  access,      // Byte access format in force.
  input  wire logic        byteWrite,   // Count byte write pulse.
  input  wire logic [7:0]  byteData,    // Count byte.
  output logic      [15:0] holdValue,   // Assembled count, registered.
  output logic             countDone,   // Pulse: a whole count was written.
  output logic             firstByte    // Pulse: first of two bytes written.
);

  logic [15:0] holdReg;
  logic [15:0] holdNext;
  logic        doneReg;
  logic        firstReg;
  logic        highNextReg;
  logic        highNextNext;

  // Byte steering: low-only clears the high byte, high-only the low byte.
  wire isLow   = byteWrite && access == itc_pkg::ACC_LOW;
  wire isHigh  = byteWrite && access == itc_pkg::ACC_HIGH;
  wire isBoth  = byteWrite && access == itc_pkg::ACC_BOTH;
  wire bothLow = isBoth && !highNextReg;
  wire bothHi  = isBoth && highNextReg;

  assign holdNext = isLow   ? {itc_pkg::BYTE_ZERO, byteData} :
                    isHigh  ? {byteData, itc_pkg::BYTE_ZERO} :
                    bothLow ? {holdReg[15:8], byteData} :
                    bothHi  ? {byteData, holdReg[7:0]} : holdReg;
  assign highNextNext = ctlWrite ? 1'b0 : (bothLow ? 1'b1 : (bothHi ? 1'b0 : highNextReg));

  // Holding register and write-completion pulses.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      holdReg     <= itc_pkg::CNT_ZERO;
      doneReg     <= 1'b0;
      firstReg    <= 1'b0;
      highNextReg <= 1'b0;
    end else begin
      holdReg     <= holdNext;
      doneReg     <= isLow || isHigh || bothHi;  // [R22]
      firstReg    <= bothLow;
      highNextReg <= highNextNext;
    end
  end

  assign holdValue = holdReg;
  assign countDone = doneReg;
  assign firstByte = firstReg;

endmodule // itc_count_hold

// ==== logic/itc_pkg.sv ====
// ----------------------------------------------------------------------------
// Shared types and constants of the interval timer channel.
// ----------------------------------------------------------------------------
package itc_pkg;

  // Control word layout, most significant field first.
  typedef struct packed {
    logic [1:0] chanSel;   // Channel select field.
    logic [1:0] access;    // Byte access format.
    logic [2:0] mode;      // Waveform mode field.
    logic       bcd;       // Decimal arithmetic when set.
  } itc_ctrl_type;

  // Phases of the counting element.
  typedef enum logic [1:0] {
    PH_IDLE  = 2'b00,      // No usable count yet.
    PH_LOAD  = 2'b01,      // Count loads on the next falling edge.
    PH_RUN   = 2'b10,      // Counting.
    PH_ARMED = 2'b11       // One-shot waiting for a trigger.
  } itc_phase_type;

  // Byte access formats.
  localparam logic [1:0] ACC_LATCH = 2'h0;
  localparam logic [1:0] ACC_LOW   = 2'h1;
  localparam logic [1:0] ACC_HIGH  = 2'h2;
  localparam logic [1:0] ACC_BOTH  = 2'h3;

  // Waveform mode codes; rate and square ignore the top bit.
  localparam logic [2:0] MODE_EVENT  = 3'h0;
  localparam logic [2:0] MODE_SHOT   = 3'h1;
  localparam logic [1:0] RATE_LOW2   = 2'h2;
  localparam logic [1:0] SQUARE_LOW2 = 2'h3;

  // Reset values and count constants.
  localparam itc_ctrl_type CTRL_RESET = 8'h10;
  localparam logic [15:0]  CNT_ZERO   = 16'h0000;
  localparam logic [15:0]  CNT_ONE    = 16'h0001;
  localparam logic [15:0]  CNT_TWO    = 16'h0002;
  localparam logic [7:0]   BYTE_ZERO  = 8'h00;

endpackage

// ==== tb/itc_proc_model.sv ====
`timescale 1ns/1ns
// ----------------------------------------------------------------------------
// Processor model: writes control words and counts over the byte bus.
// ----------------------------------------------------------------------------
module itc_proc_model (
  input  wire logic       clk,         // System clock.
  output logic            ctlWrite,    // Control word write pulse.
  output logic            countWrite,  // Count byte write pulse.
  output logic      [7:0] busData      // Written byte.
);
  itc_pkg::itc_ctrl_type ctrlShadow;   // Last control word, sets the count format.

  // Bus is quiet at time zero; the shadow matches the channel's reset format.
  initial begin
    ctlWrite   = 1'b0;
    countWrite = 1'b0;
    busData    = 8'h00;
    ctrlShadow = itc_pkg::CTRL_RESET;
  end

  // One write cycle; the released bus shows the inverse so stale data is not seen.
  task automatic pulse(input logic isCtl, input logic [7:0] data);
    @(negedge clk);
    ctlWrite   = isCtl;
    countWrite = ~isCtl;
    busData    = data;
    @(negedge clk);
    ctlWrite   = 1'b0;
    countWrite = 1'b0;
    busData    = ~data;
    repeat (2) @(negedge clk);
  endtask

  // Control word comes first and fixes the byte format of later counts.
  task automatic writeCtrl(input logic [7:0] data);
    ctrlShadow = data;
    pulse(1'b1, data);
  endtask

  // A single count byte.
  task automatic writeByte(input logic [7:0] data);
    pulse(1'b0, data);
  endtask

  // A whole count, split into bytes as the access field asks.
  task automatic writeCount(input logic [15:0] value);
    if (ctrlShadow.mode[1:0] == itc_pkg::RATE_LOW2 && value == itc_pkg::CNT_ONE) begin
      return;
    end
    case (ctrlShadow.access)
      itc_pkg::ACC_LOW: writeByte(value[7:0]);
      itc_pkg::ACC_HIGH: writeByte(value[15:8]);
      itc_pkg::ACC_BOTH: begin
        writeByte(value[7:0]);
        writeByte(value[15:8]);
      end
      default: ;
    endcase
  endtask
endmodule // itc_proc_model

// ==== tb/tb.sv ====
`timescale 1ns/1ns
// ----------------------------------------------------------------------------
// Testbench of one timer channel, modes 0 to 3.
// ----------------------------------------------------------------------------
module tb;
  logic        clk;             // System clock.
  logic        rstn;            // Reset, active low.
  logic        countClk;        // Channel count clock.
  logic        gate;            // Channel gate.
  logic        chanOut;         // Channel output.
  logic        ctlWrite;        // Control word write.
  logic        countWrite;      // Count byte write.
  logic [7:0]  busData;         // Written byte.
  logic [15:0] countValue;      // Counting element.
  int          fails;           // Mismatches.
  int          samplesChecked;  // Comparisons made.

  itc_channel dut (.clk(clk), .rstn(rstn), .ctlWrite(ctlWrite), .countWrite(countWrite),
    .busData(busData), .countClk(countClk), .gate(gate), .chanOut(chanOut),
    .countValue(countValue));
  itc_proc_model cpu (.clk(clk), .ctlWrite(ctlWrite), .countWrite(countWrite),
    .busData(busData));

  // The 50 MHz system clock.
  initial clk = 1'b0;
  always #10 clk = ~clk;

  // ----------------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------------
  // One count-clock fall, then time for the channel to react.
  task automatic fall();
    @(negedge clk) countClk = 1'b1;
    @(negedge clk) countClk = 1'b0;
    repeat (2) @(negedge clk);
  endtask

  // Gate level change, then time for the channel to react.
  task automatic setGate(input logic level);
    @(negedge clk) gate = level;
    @(negedge clk);
  endtask

  // Output level comparison.
  task automatic checkOut(input logic exp, input string what);
    samplesChecked++;
    if (chanOut !== exp) begin
      fails++;
      $display("ERROR %s expected %b seen %b", what, exp, chanOut);
    end
  endtask

  // Counting element comparison.
  task automatic checkCnt(input logic [15:0] exp, input string what);
    samplesChecked++;
    if (countValue !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp, countValue);
    end
  endtask

  // Processor writes; the scenario values travel through these into the model.
  task automatic writeCtrl(input logic [7:0] word);
    cpu.writeCtrl(word);
  endtask

  task automatic writeCount(input logic [15:0] value);
    cpu.writeCount(value);
  endtask

  task automatic writeByte(input logic [7:0] data);
    cpu.writeByte(data);
  endtask

  // A run of falls against tables of element values and output levels, first entry leftmost.
  task automatic runFalls(input int n, input logic [5:0][15:0] ce, input logic [5:0] ob);
    for (int i = 0; i < n; i++) begin
      fall();
      checkCnt(ce[5-i], "element in sequence");
      checkOut(ob[5-i], "output in sequence");
    end
  endtask

  // ----------------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------------
  // Event counter: load, gate hold, first byte drop, load with gate low.
  task automatic eventMode();
    writeCtrl(8'h30);
    checkOut(1'b0, "event output after control");
    writeCount(16'h0003);
    fall();
    fall();
    checkCnt(16'h0002, "event after two falls");
    setGate(1'b0);
    fall();
    checkCnt(16'h0002, "event held by gate");
    checkOut(1'b0, "event output under gate");
    setGate(1'b1);
    fall();
    checkOut(1'b0, "event output at one");
    fall();
    checkOut(1'b1, "event output after N+1 falls");
    writeByte(8'h02);
    checkOut(1'b0, "event output after first byte");
    setGate(1'b0);
    writeByte(8'h00);
    fall();
    checkCnt(16'h0002, "event load with gate low");
    fall();
    checkCnt(16'h0002, "event hold after load");
    setGate(1'b1);
    runFalls(2, {16'h1, 16'h0, 64'h0}, 6'b010000);
  endtask

  // Zero count, decimal arithmetic and high-byte-only format.
  task automatic countFormats();
    writeCtrl(8'h31);
    writeCount(16'h0000);
    runFalls(2, {16'h0, 16'h9999, 64'h0}, 6'b000000);
    writeCtrl(8'h30);
    writeCount(16'h0000);
    runFalls(2, {16'h0, 16'hffff, 64'h0}, 6'b000000);
    writeCtrl(8'h20);
    writeCount(16'h0100);
    fall();
    checkCnt(16'h0100, "high byte only count");
    writeCtrl(8'h00);
    fall();
    checkCnt(16'h00ff, "latch command ignored");
  endtask

  // One-shot: trigger, no repeat, retrigger with a count written meanwhile.
  task automatic oneShot();
    setGate(1'b0);
    writeCtrl(8'h12);
    checkOut(1'b1, "shot output after control");
    writeCount(16'h0003);
    fall();
    checkOut(1'b1, "shot output without trigger");
    setGate(1'b1);
    fall();
    checkCnt(16'h0003, "shot load on trigger");
    checkOut(1'b0, "shot output on trigger");
    setGate(1'b0);
    runFalls(3, {16'h2, 16'h1, 16'h0, 48'h0}, 6'b001000);
    fall();
    checkOut(1'b1, "shot without repeat");
    setGate(1'b1);
    fall();
    writeCount(16'h0005);
    fall();
    checkCnt(16'h0002, "shot keeps pulse after write");
    setGate(1'b0);
    setGate(1'b1);
    fall();
    checkCnt(16'h0005, "shot retrigger loads new count");
    checkOut(1'b0, "shot output on retrigger");
  endtask

  // Rate generator with the top mode bit set, gate inhibit, count change.
  task automatic rateGen();
    writeCtrl(8'h1c);
    checkOut(1'b1, "rate output after control");
    writeCount(16'h0003);
    runFalls(6, {16'h3, 16'h2, 16'h1, 16'h3, 16'h2, 16'h1}, 6'b110110);
    setGate(1'b0);
    checkOut(1'b1, "rate output forced by gate");
    fall();
    checkCnt(16'h0001, "rate inhibited by gate");
    setGate(1'b1);
    fall();
    checkCnt(16'h0003, "rate reload after trigger");
    writeCount(16'h0004);
    runFalls(3, {16'h2, 16'h1, 16'h4, 48'h0}, 6'b101000);
  endtask

  // Square wave with odd and even counts, gate inhibit.
  task automatic squareWave();
    writeCtrl(8'h16);
    checkOut(1'b1, "square output after control");
    writeCount(16'h0005);
    runFalls(6, {16'h4, 16'h2, 16'h0, 16'h4, 16'h2, 16'h4}, 6'b111001);
    writeCtrl(8'h16);
    writeCount(16'h0004);
    runFalls(5, {16'h4, 16'h2, 16'h4, 16'h2, 16'h4, 16'h0}, 6'b110010);
    runFalls(2, {16'h2, 16'h4, 64'h0}, 6'b100000);
    setGate(1'b0);
    checkOut(1'b1, "square output forced by gate");
    fall();
    checkCnt(16'h0004, "square inhibited by gate");
  endtask

  // ----------------------------------------------------------------------------
  // Run control
  // ----------------------------------------------------------------------------
  // Verdict and end of run.
  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", samplesChecked, fails);
    if (fails == 0 && samplesChecked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Main sequence: reset for two cycles, then every scenario.
  initial begin
    fails = 0;
    samplesChecked = 0;
    rstn = 1'b0;
    countClk = 1'b0;
    gate = 1'b1;
    repeat (2) @(negedge clk);
    checkOut(1'b0, "output in reset");
    checkCnt(16'h0000, "element in reset");
    rstn = 1'b1;
    eventMode();
    countFormats();
    oneShot();
    rateGen();
    squareWave();
    conclude();
  end

  // Watchdog: the scenarios need well under 5000 cycles.
  initial begin
    #200000;
    fails++;
    conclude();
  end
endmodule // tb
